// >>> design/dvm_ctrl.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
// Behaviour
// RQ1: sign low while input is negative
// RQ2: segment outputs active low when lit
// RQ3: digit selects low in turn, top first
// RQ4: bcd and segments show same digit together
// RQ5: select asserted with its own digit data
// RQ6: suppress leading zeros while suppress input high
// RQ7: blank input: segments off, bcd all ones
// RQ8: overload high when count hits 4000
// RQ9: external comparator feeds comparator input
// RQ10: auto-zero high during offset correction phase
// RQ11: input switch high only during integration
// RQ12: integration lasts exactly 2000 periods
// RQ13: one reference, opposite to input polarity
// RQ14: count until comparator flips, then stop
// RQ15: 3999 max; at 4000 stop, overrange
// RQ16: auto-zero phase: only null switch on
// RQ17: measurement cycle repeats every 8000 periods
// RQ18: counter advances on conversion clock fall
// RQ19: latch result on next rising edge
// RQ20: blanking latch set each scan, cleared nonzero
// RQ21: units digit always displayed
// RQ22: suppress input low overrides zero blanking
// RQ23: auto-zero goes high when measurement completes
// RQ24: each select repeats at clock over forty
// RQ25: decoded digits; flashing eights on overrange
module dvm_ctrl
	import dvm_pkg::*;
#(
	parameter int unsigned HALF_DIV = DVM_HALF_DIV
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analogue side
	input wire logic comp_in,
	output logic input_switch,
	output logic ref_pos,
	output logic ref_neg,
	output logic null_switch,
	output logic overload,
	// display side
	input wire logic lead_suppress_in,
	input wire logic blank_in,
	output logic sign_n,
	output logic [6:0] seg_n,
	output logic [3:0] bcd,
	output logic digit_sel_first_n,
	output logic digit_sel_second_n,
	output logic digit_sel_third_n,
	output logic digit_sel_fourth_n
);
	localparam logic [12:0] CYC_LAST = 13'(DVM_CYCLE_PERIODS - 1);
	localparam logic [12:0] INTEG_LAST = 13'(DVM_INTEG_PERIODS - 1);
	localparam logic [3:0] SUB_LAST = 4'(DVM_DIGIT_PERIODS - 1);
	localparam logic [12:0] FLASH_HALF = 13'(DVM_CYCLE_PERIODS / 2);

	logic [1:0] ctrl;
	logic [31:0] div_cnt;
	logic conv_lvl;
	logic fall_tick;
	logic rise_tick;
	logic [1:0] comp_sync;
	logic [1:0] lead_sync;
	logic [1:0] blank_sync;
	logic comp_s;
	logic lead_s;
	logic blank_s;
	dvm_phase_t phase;
	logic [12:0] cyc;
	logic [15:0] count;
	logic neg_in;
	logic pend;
	logic pend_ovr;
	logic [15:0] reading;
	logic rd_neg;
	logic rd_ovr;
	logic done;
	logic [3:0] sub;
	logic [1:0] idx;
	logic blank_latch;
	logic [3:0] cur;
	logic suppress;
	logic dark;
	logic [3:0] shown;
	logic [31:0] rd_val;
	logic mapped;
	logic ctrl_wr;
	logic status_rd;

	// bcd increment with decimal carry
	function automatic logic [15:0] bcd_inc(input logic [15:0] v);
		logic [15:0] r;
		logic c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (c) begin
				if (r[i*4 +: 4] == 4'h9) begin
					r[i*4 +: 4] = 4'h0;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return r;
	endfunction : bcd_inc

	// pins cross into sys_clk through two flops
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			comp_sync <= 2'h0;
			lead_sync <= 2'h0;
			blank_sync <= 2'h0;
		end else begin
			comp_sync <= {comp_sync[0], comp_in}; // RQ9
			lead_sync <= {lead_sync[0], lead_suppress_in};
			blank_sync <= {blank_sync[0], blank_in};
		end
	end
	assign comp_s = comp_sync[1];
	assign lead_s = lead_sync[1];
	assign blank_s = blank_sync[1];

	// conversion clock as enables; fall and rise half a period apart
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			div_cnt <= 32'h0;
			conv_lvl <= 1'b0;
		end else if (div_cnt == HALF_DIV - 1) begin
			div_cnt <= 32'h0;
			conv_lvl <= ~conv_lvl;
		end else begin
			div_cnt <= div_cnt + 32'h1;
		end
	end
	assign fall_tick = (div_cnt == HALF_DIV - 1) && conv_lvl; // RQ18
	assign rise_tick = (div_cnt == HALF_DIV - 1) && !conv_lvl;

	// measurement sequencer, steps on falling ticks; a stop parks it at once
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			phase <= DVM_INTEG;
			cyc <= 13'h0;
			count <= 16'h0;
			neg_in <= 1'b0;
		end else if (!ctrl[DVM_CTRL_RUN_BIT]) begin
			// stopped: park in auto-zero, restart cleanly when run returns
			phase <= DVM_AZERO;
			cyc <= CYC_LAST;
		end else if (fall_tick) begin
			cyc <= (cyc == CYC_LAST) ? 13'h0 : cyc + 13'h1; // RQ17
			unique case (phase)
				DVM_INTEG: begin
					if (cyc == INTEG_LAST) begin // RQ12
						neg_in <= comp_s; // RQ13
						count <= 16'h0;
						phase <= DVM_DEINT;
					end
				end
				DVM_DEINT: begin
					if (comp_s != neg_in) begin
						phase <= DVM_AZERO; // RQ14
					end else if (count == DVM_MAX_BCD) begin
						count <= DVM_OVER_BCD; // RQ15
						phase <= DVM_AZERO;
					end else begin
						count <= bcd_inc(count); // RQ18
					end
				end
				DVM_AZERO: begin
					if (cyc == CYC_LAST) begin
						phase <= DVM_INTEG;
					end
				end
			endcase
		end
	end

	// end of de-integration waits for the next rising tick to latch
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pend <= 1'b0;
			pend_ovr <= 1'b0;
		end else if (fall_tick && phase == DVM_DEINT && ctrl[DVM_CTRL_RUN_BIT]) begin
			if (comp_s != neg_in) begin
				pend <= 1'b1;
				pend_ovr <= 1'b0;
			end else if (count == DVM_MAX_BCD) begin
				pend <= 1'b1;
				pend_ovr <= 1'b1; // RQ8
			end
		end else if (rise_tick) begin
			pend <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			reading <= 16'h0;
			rd_neg <= 1'b0;
			rd_ovr <= 1'b0;
		end else if (rise_tick && pend) begin
			reading <= count; // RQ19
			rd_neg <= neg_in;
			rd_ovr <= pend_ovr; // RQ8
		end
	end

	// new-reading flag: a latch in the same cycle as a read keeps it set
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			done <= 1'b0;
		end else if (rise_tick && pend) begin
			done <= 1'b1;
		end else if (status_rd) begin
			done <= 1'b0;
		end
	end

	// switch drive, registered so no glitches reach the analogue switches
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			input_switch <= 1'b0;
			ref_pos <= 1'b0;
			ref_neg <= 1'b0;
			null_switch <= 1'b0;
			overload <= 1'b0;
			sign_n <= 1'b1;
		end else begin
			input_switch <= (phase == DVM_INTEG); // RQ11 RQ16
			ref_pos <= (phase == DVM_DEINT) && neg_in; // RQ13
			ref_neg <= (phase == DVM_DEINT) && !neg_in; // RQ13
			null_switch <= (phase == DVM_AZERO); // RQ10 RQ16 RQ23
			overload <= rd_ovr; // RQ8
			sign_n <= ~rd_neg; // RQ1
		end
	end

	// scan: ten periods per digit, forty per full scan
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sub <= 4'h0;
			idx <= 2'h0;
		end else if (fall_tick) begin
			if (sub == SUB_LAST) begin
				sub <= 4'h0;
				idx <= idx + 2'h1; // RQ3 RQ24
			end else begin
				sub <= sub + 4'h1;
			end
		end
	end

	assign cur = reading[(3 - idx) * 4 +: 4];

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			blank_latch <= 1'b1;
		end else if (fall_tick && sub == SUB_LAST && idx == 2'h3) begin
			blank_latch <= 1'b1; // RQ20
		end else if (cur != 4'h0 || !lead_s) begin
			blank_latch <= 1'b0; // RQ20 RQ22
		end
	end

	// RQ6 RQ21
	assign suppress = lead_s && blank_latch && cur == 4'h0 &&
		{2'h0, idx} != DVM_UNITS_IDX && !rd_ovr;
	// overrange flashes once per measurement cycle, dark for its second half
	assign dark = blank_s || ctrl[DVM_CTRL_BLANK_BIT] || suppress ||
		(rd_ovr && cyc >= FLASH_HALF); // RQ25
	assign shown = rd_ovr ? DVM_BCD_EIGHT : cur; // RQ25

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			bcd <= DVM_BCD_BLANK;
			seg_n <= DVM_SEG_OFF;
			digit_sel_first_n <= 1'b1;
			digit_sel_second_n <= 1'b1;
			digit_sel_third_n <= 1'b1;
			digit_sel_fourth_n <= 1'b1;
		end else begin
			// RQ4 RQ5 RQ7
			bcd <= (blank_s || ctrl[DVM_CTRL_BLANK_BIT]) ? DVM_BCD_BLANK : shown;
			seg_n <= dark ? DVM_SEG_OFF : ~dvm_seg7(shown); // RQ2 RQ7
			digit_sel_first_n <= (idx != 2'h0); // RQ3 RQ5
			digit_sel_second_n <= (idx != 2'h1);
			digit_sel_third_n <= (idx != 2'h2);
			digit_sel_fourth_n <= (idx != 2'h3);
		end
	end

	// apb: zero wait states, read data captured in setup phase
	assign pready = 1'b1;
	assign mapped = (paddr == DVM_CTRL_OFS) || (paddr == DVM_STATUS_OFS);
	assign pslverr = psel && penable && !mapped;
	assign ctrl_wr = psel && penable && pwrite && paddr == DVM_CTRL_OFS;
	assign status_rd = psel && penable && !pwrite && paddr == DVM_STATUS_OFS;

	always_comb begin
		rd_val = 32'h0;
		if (paddr == DVM_CTRL_OFS) begin
			rd_val[1:0] = ctrl;
		end else if (paddr == DVM_STATUS_OFS) begin
			rd_val[15:0] = reading;
			rd_val[DVM_ST_NEG_BIT] = rd_neg;
			rd_val[DVM_ST_OVR_BIT] = rd_ovr;
			rd_val[DVM_ST_PHASE_LSB +: 2] = phase;
			rd_val[DVM_ST_DONE_BIT] = done;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_val;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl <= DVM_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl <= pwdata[1:0];
		end
	end
endmodule : dvm_ctrl

// >>> design/dvm_pkg.sv
package dvm_pkg;
	// conversion timing, in conversion-clock periods
	localparam int unsigned DVM_INTEG_PERIODS = 2000;
	localparam int unsigned DVM_CYCLE_PERIODS = 8000;
	localparam logic [15:0] DVM_OVER_BCD = 16'h4000;
	localparam logic [15:0] DVM_MAX_BCD = 16'h3999;
	// display scan: each digit shown for this many conversion periods
	localparam int unsigned DVM_DIGIT_PERIODS = 10;
	localparam int unsigned DVM_NUM_DIGITS = 4;
	localparam logic [3:0] DVM_UNITS_IDX = 4'h3;
	// clocks
	localparam int unsigned DVM_SYS_CLK_HZ = 200000000;
	localparam int unsigned DVM_CONV_CLK_HZ = 20000;
	localparam int unsigned DVM_HALF_DIV = DVM_SYS_CLK_HZ / (2 * DVM_CONV_CLK_HZ);
	// register byte offsets
	localparam logic [7:0] DVM_CTRL_OFS = 8'h00;
	localparam logic [7:0] DVM_STATUS_OFS = 8'h04;
	// control fields and reset value
	localparam int unsigned DVM_CTRL_RUN_BIT = 0;
	localparam int unsigned DVM_CTRL_BLANK_BIT = 1;
	localparam logic [1:0] DVM_CTRL_RESET = 2'h1;
	// status fields, then display codes
	localparam int unsigned DVM_ST_NEG_BIT = 16;
	localparam int unsigned DVM_ST_OVR_BIT = 17;
	localparam int unsigned DVM_ST_PHASE_LSB = 18;
	localparam int unsigned DVM_ST_DONE_BIT = 20;
	localparam logic [3:0] DVM_BCD_BLANK = 4'hf;
	localparam logic [3:0] DVM_BCD_EIGHT = 4'h8;
	localparam logic [6:0] DVM_SEG_OFF = 7'h7f;

	typedef enum logic [1:0] {
		DVM_INTEG,
		DVM_DEINT,
		DVM_AZERO
	} dvm_phase_t;

	// active-high segment pattern, bit order g f e d c b a
	function automatic logic [6:0] dvm_seg7(input logic [3:0] d);
		logic [6:0] p;
		p = 7'h00;
		unique case (d)
			4'h0: p = 7'h3f;
			4'h1: p = 7'h06;
			4'h2: p = 7'h5b;
			4'h3: p = 7'h4f;
			4'h4: p = 7'h66;
			4'h5: p = 7'h6d;
			4'h6: p = 7'h7d;
			4'h7: p = 7'h07;
			4'h8: p = 7'h7f;
			4'h9: p = 7'h6f;
			default: p = 7'h00;
		endcase
		return p;
	endfunction : dvm_seg7
endpackage : dvm_pkg

// >>> verification/dvm_ctrl_monitor.sv
`timescale 1ns/10ps
module dvm_ctrl_monitor
	import dvm_pkg::*;
#(
	parameter int unsigned HALF_DIV = DVM_HALF_DIV
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// analogue side
	input wire logic input_switch,
	input wire logic ref_pos,
	input wire logic ref_neg,
	input wire logic null_switch,
	// display side
	input wire logic blank_in,
	input wire logic [6:0] seg_n,
	input wire logic [3:0] bcd,
	input wire logic digit_sel_first_n,
	input wire logic digit_sel_second_n,
	input wire logic digit_sel_third_n,
	input wire logic digit_sel_fourth_n
);
	localparam int unsigned PER = 2 * HALF_DIV;
	int unsigned integ_cnt;
	int unsigned ref_cnt;
	int unsigned cyc_cnt;
	logic seen_start;
	int unsigned scan_cnt;
	logic seen_scan;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// first start after reset has no predecessor to measure from
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			integ_cnt <= 0;
			ref_cnt <= 0;
			cyc_cnt <= 0;
			seen_start <= 1'b0;
			scan_cnt <= 0;
			seen_scan <= 1'b0;
		end else begin
			scan_cnt <= $fell(digit_sel_first_n) ? 1 : scan_cnt + 1;
			seen_scan <= seen_scan | $fell(digit_sel_first_n);
			integ_cnt <= input_switch ? integ_cnt + 1 : 0;
			ref_cnt <= (ref_pos | ref_neg) ? ref_cnt + 1 : 0;
			cyc_cnt <= $rose(input_switch) ? 1 : cyc_cnt + 1;
			seen_start <= seen_start | $rose(input_switch);
		end
	end
	a_integ_len: assert property (
		$fell(input_switch) |-> integ_cnt == 2000 * PER)
		else $error("integration length wrong");
	a_cycle_len: assert property (
		$rose(input_switch) && seen_start |-> cyc_cnt == 8000 * PER)
		else $error("cycle length wrong");
	a_ref_bound: assert property (ref_cnt <= 4000 * PER)
		else $error("de-integration too long");
	a_one_ref: assert property (!(ref_pos && ref_neg))
		else $error("both references on");
	a_ref_follows: assert property (
		$fell(input_switch) |-> ref_pos ^ ref_neg)
		else $error("no reference after integration");
	a_deint_end: assert property (
		$fell(ref_pos | ref_neg) |-> null_switch && !input_switch)
		else $error("no auto-zero after de-integration");
	a_azero_only: assert property (
		null_switch |-> !input_switch && !ref_pos && !ref_neg)
		else $error("switch on during auto-zero");
	a_switch_only: assert property (
		input_switch |-> !ref_pos && !ref_neg)
		else $error("reference on during integration");
	a_sel_single: assert property ($countones({digit_sel_first_n,
		digit_sel_second_n, digit_sel_third_n, digit_sel_fourth_n}) >= 3)
		else $error("two digit selects low");
	a_scan_order: assert property (
		($fell(digit_sel_second_n) |-> !$past(digit_sel_first_n)) and
		($fell(digit_sel_third_n) |-> !$past(digit_sel_second_n)) and
		($fell(digit_sel_fourth_n) |-> !$past(digit_sel_third_n)))
		else $error("digit scan out of order");
	a_scan_rate: assert property (
		$fell(digit_sel_first_n) && seen_scan |->
		scan_cnt == DVM_NUM_DIGITS * DVM_DIGIT_PERIODS * PER)
		else $error("scan rate wrong");
	a_units_shown: assert property (
		!digit_sel_fourth_n && bcd == 4'h0 |-> seg_n == 7'h40)
		else $error("zero units digit suppressed");
	a_blank_out: assert property (blank_in [*4] |=>
		bcd == 4'hf && seg_n == 7'h7f)
		else $error("blanking ignored");
endmodule : dvm_ctrl_monitor

// >>> verification/dvm_front_model.sv
`timescale 1ns/10ps
module dvm_front_model #(
	parameter int unsigned PER = 4
) (
	// phase outputs of the block
	input wire logic sys_clk,
	input wire logic ref_pos,
	input wire logic ref_neg,
	input wire logic null_switch,
	// quantity under measurement
	input wire logic neg,
	input wire logic [15:0] mag,
	// comparator
	output logic comp_in
);
	int unsigned ramp = 0;
	// high while integrator positive, i.e. input negative
	always @(posedge sys_clk) begin
		ramp <= (ref_pos | ref_neg) ? ramp + 1 : 0;
		if (ref_pos | ref_neg)
			comp_in <= (ramp + 1 >= mag * PER) ? !neg : neg;
		else if (null_switch)
			comp_in <= !comp_in; // dithers about zero while nulling
		else
			comp_in <= neg;
	end
endmodule : dvm_front_model

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	fail_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
	import dvm_pkg::*;
	localparam int unsigned HALF_DIV = 2;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic lead_suppress_in = 1'b1;
	logic blank_in = 1'b0;
	logic neg = 1'b1;
	logic [15:0] mag = 16'd125;
	logic saw_pos = 1'b0;
	logic saw_neg = 1'b0;
	logic saw_clr = 1'b0;
	logic [31:0] prdata, q;
	logic pready, pslverr, err, comp_in, input_switch, ref_pos, ref_neg;
	logic null_switch, overload, sign_n, sel1_n, sel2_n, sel3_n, sel4_n;
	logic [6:0] seg_n;
	logic [3:0] bcd;
	int fail_count = 0;
	int check_count = 0;
	always #2.5 sys_clk = ~sys_clk;
	// one process owns the flags; scenarios only request a clear
	always @(posedge sys_clk) begin
		if (saw_clr) begin
			saw_pos <= 1'b0;
			saw_neg <= 1'b0;
		end else begin
			if (ref_pos) saw_pos <= 1'b1;
			if (ref_neg) saw_neg <= 1'b1;
		end
	end
	dvm_ctrl #(.HALF_DIV(HALF_DIV)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .comp_in(comp_in), .input_switch(input_switch),
		.ref_pos(ref_pos), .ref_neg(ref_neg), .null_switch(null_switch),
		.overload(overload), .lead_suppress_in(lead_suppress_in),
		.blank_in(blank_in), .sign_n(sign_n), .seg_n(seg_n), .bcd(bcd),
		.digit_sel_first_n(sel1_n), .digit_sel_second_n(sel2_n),
		.digit_sel_third_n(sel3_n), .digit_sel_fourth_n(sel4_n));
	dvm_front_model #(.PER(2 * HALF_DIV)) u_front (.sys_clk(sys_clk),
		.ref_pos(ref_pos), .ref_neg(ref_neg), .null_switch(null_switch),
		.neg(neg), .mag(mag), .comp_in(comp_in));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		`CHK("pready", 1'b1, pready)
		if (pready !== 1'b1) end_of_test();
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic pick(input int w);
		logic [4:0] s;
		s = {sel4_n, input_switch, sel2_n, sel1_n, null_switch};
		return s[w];
	endfunction : pick
	task automatic wait_for(input int w, input logic lvl);
		int n;
		n = 0;
		while (pick(w) !== lvl) begin
			@(posedge sys_clk);
			n++;
			if (n > 40000) begin
				`CHK("wait", lvl, pick(w))
				end_of_test();
			end
		end
		@(posedge sys_clk);
	endtask : wait_for
	task automatic t_regs;
		apb(1'b0, DVM_CTRL_OFS, 32'h0);
		`CHK("ctrl", 32'h1, q)
		apb(1'b0, 8'h08, 32'h0);
		`CHK("unmapped", 1'b1, err)
		apb(1'b1, DVM_CTRL_OFS, 32'h3);
		repeat (8) @(posedge sys_clk);
		`CHK("soft blank", DVM_BCD_BLANK, bcd)
		apb(1'b1, DVM_CTRL_OFS, 32'h1);
		blank_in <= 1'b1;
		repeat (8) @(posedge sys_clk);
		`CHK("blank seg", DVM_SEG_OFF, seg_n)
		`CHK("blank bcd", DVM_BCD_BLANK, bcd)
		blank_in <= 1'b0;
		$display("test regs done");
	endtask : t_regs
	task automatic t_neg;
		wait_for(0, 1'b1);
		repeat (8) @(posedge sys_clk);
		`CHK("ref pos", 1'b1, saw_pos)
		`CHK("ref neg", 1'b0, saw_neg)
		`CHK("sign", 1'b0, sign_n)
		apb(1'b0, DVM_STATUS_OFS, 32'h0);
		`CHK("reading", 12'h012, q[15:4])
		`CHK("flags", 5'h19, q[20:16])
		wait_for(4, 1'b0);
		wait_for(1, 1'b0);
		`CHK("top blank", DVM_SEG_OFF, seg_n)
		wait_for(2, 1'b0);
		`CHK("d2 bcd", 4'h1, bcd)
		`CHK("d2 seg", 7'h79, seg_n)
		lead_suppress_in <= 1'b0;
		wait_for(4, 1'b0);
		wait_for(1, 1'b0);
		`CHK("top zero", 7'h40, seg_n)
		lead_suppress_in <= 1'b1;
		$display("test negative done");
	endtask : t_neg
	task automatic t_over;
		mag <= 16'd5000;
		neg <= 1'b0;
		wait_for(3, 1'b1);
		saw_clr <= 1'b1;
		@(posedge sys_clk);
		saw_clr <= 1'b0;
		wait_for(0, 1'b1);
		repeat (8) @(posedge sys_clk);
		`CHK("ref neg", 1'b1, saw_neg)
		`CHK("ref pos", 1'b0, saw_pos)
		`CHK("overload", 1'b1, overload)
		`CHK("sign", 1'b1, sign_n)
		apb(1'b0, DVM_STATUS_OFS, 32'h0);
		`CHK("over val", DVM_OVER_BCD, q[15:0])
		`CHK("over bit", 1'b1, q[17])
		wait_for(4, 1'b0);
		wait_for(1, 1'b0);
		`CHK("eights", DVM_BCD_EIGHT, bcd)
		`CHK("eights dark", DVM_SEG_OFF, seg_n)
		wait_for(3, 1'b1);
		wait_for(4, 1'b0);
		wait_for(1, 1'b0);
		`CHK("eights lit", 7'h00, seg_n)
		$display("test overrange done");
	endtask : t_over
	initial begin
		repeat (10) @(posedge sys_clk);
		`CHK("rst seg", DVM_SEG_OFF, seg_n)
		`CHK("rst bcd", DVM_BCD_BLANK, bcd)
		nrst <= 1'b1;
		t_regs();
		t_neg();
		t_over();
		end_of_test();
	end
endmodule : tb_top
bind dvm_ctrl dvm_ctrl_monitor #(.HALF_DIV(HALF_DIV)) u_mon (
	.sys_clk(sys_clk), .nrst(nrst), .input_switch(input_switch),
	.ref_pos(ref_pos), .ref_neg(ref_neg), .null_switch(null_switch),
	.blank_in(blank_in), .seg_n(seg_n), .bcd(bcd),
	.digit_sel_first_n(digit_sel_first_n),
	.digit_sel_second_n(digit_sel_second_n),
	.digit_sel_third_n(digit_sel_third_n),
	.digit_sel_fourth_n(digit_sel_fourth_n));
